// ---- verilog/ebrpc_pkg.sv ----
`default_nettype none

package ebrpc_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the APB side.
    // ------------------------------------------------------------------
    localparam int          APB_AW         = 12;
    localparam logic [11:0] ADDR_PMODE     = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_GRANTS    = 12'h008;
    localparam logic [31:0] PMODE_RESET    = 32'h00000000;
    localparam logic [31:0] PMODE_MASK     = 32'h00000001;
    localparam int          PMODE_CLKDIS   = 0;
    localparam logic [31:0] RDATA_IDLE     = 32'h00000000;

    // ------------------------------------------------------------------
    // Status register field positions; status_bits holds req at bit 4 and xio_mode at bit 3.
    // ------------------------------------------------------------------
    localparam int ST_GRANT  = 0;
    localparam int ST_CHOLD  = 1;
    localparam int ST_DRAIN  = 2;
    localparam int ST_REQ    = 3;
    localparam int ST_XIO    = 4;
    localparam int ST_FLOATN = 5;
    localparam int ST_CYCLE_CLOCK_OUT_DISABLE = 6;
    localparam int ST_SEL    = 7;
    localparam int ST_W      = 8;

    // ------------------------------------------------------------------
    // Machine cycle timing in reference clock cycles.
    // ------------------------------------------------------------------
    localparam int         MC_W    = 2;
    localparam logic [1:0] MC_LAST = 2'h3;
    localparam logic [1:0] MC_HALF = 2'h1;
    localparam logic [1:0] MC_ZERO = 2'h0;

    // ------------------------------------------------------------------
    // Pin widths, idle levels and the core-side bus bundle.
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 18;
    localparam int          DATA_W     = 16;
    localparam int          CTRL_W     = 4;
    localparam int          GRANT_W    = 16;
    localparam logic [3:0]  CTRL_IDLE  = 4'hF;
    localparam logic [15:0] GRANT_ZERO = 16'h0000;
    localparam logic [15:0] GRANT_ONE  = 16'h0001;

    typedef struct packed {
        logic        addr_bit_18;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic        data_drive;
        logic [3:0]  ctrl_n;
    } ebrpc_core_bus_type;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_WAIT  = 3'b010,
        ST_HELD  = 3'b100
    } ebrpc_state_type;

endpackage

`default_nettype wire

// ---- verilog/ebrpc_pad_reg.sv ----
`timescale 1ns/1ns
`default_nettype none

// Registered output pad with an active-low enable; floats under reset.
module ebrpc_pad_reg #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] value_in,
    input  wire logic             drive_in,
    output var  logic [WIDTH-1:0] value_out,
    output var  logic             oe_n_out
);

    // ------------------------------------------------------------------
    // Pad flip-flops.
    // ------------------------------------------------------------------

    // Value and enable move together so the pin never shows a stale level.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            value_out <= RESET_VAL;
            oe_n_out  <= 1'b1;
        end
        else
        begin
            value_out <= value_in;
            oe_n_out  <= ~drive_in;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/ebrpc_cycle_div.sv ----
`timescale 1ns/1ns
`default_nettype none

module ebrpc_cycle_div
    import ebrpc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic stop_in,
    output var  logic cycle_start_out,
    output var  logic level_out,
    output var  logic stopped_out
);

    // ------------------------------------------------------------------
    // Machine cycle counter.
    // ------------------------------------------------------------------
    logic [MC_W-1:0] cnt_q;
    wire             wrap = (cnt_q == MC_LAST);
    wire             half = (cnt_q == MC_HALF);

    // Stop is only looked at on the cycle boundary, which avoids runt pulses.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q           <= MC_ZERO;
            cycle_start_out <= 1'b0;
            level_out       <= 1'b1;
            stopped_out     <= 1'b0;
        end
        else
        begin
            cnt_q           <= wrap ? MC_ZERO : cnt_q + 1'b1;
            cycle_start_out <= wrap;
            if (wrap)
            begin
                stopped_out <= stop_in;
                if (!stop_in)
                    level_out <= 1'b0;
            end
            else if (half)
                level_out <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/ebrpc_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Mode pin low: select pin is input
// - Mode pin high: drive address bit 18
// - Float pin low: address outputs float
// - Acknowledged request: float address, data, control
// - Grant output shows held, floated bus
// - Float pin low: grant output floats
// - Clock output cycles at machine rate
// - Machine cycle bounded by clock falling edges
// - Disable bit one stops clock output
// - Float pin low: clock output floats
module ebrpc_top
    import ebrpc_pkg::*;
(
    input  wire logic               CLOCK_IN,
    input  wire logic               RST_N_IN,
    input  wire logic               PSEL_IN,
    input  wire logic               PENABLE_IN,
    input  wire logic               PWRITE_IN,
    input  wire logic [APB_AW-1:0]  PADDR_IN,
    input  wire logic [31:0]        PWDATA_IN,
    output var  logic [31:0]        PRDATA_OUT,
    output var  logic               PREADY_OUT,
    output var  logic               PSLVERR_OUT,
    input  wire logic               EXTERNAL_IO_MODE_PIN_IN,
    input  wire logic               EMULATION_FLOAT_PIN_N_IN,
    input  wire logic               BUS_RELEASE_REQ_N_IN,
    input  wire logic               SUBSYSTEM_SELECT_IN,
    input  wire ebrpc_core_bus_type CORE_BUS_IN,
    input  wire logic               CORE_ACCESS_BUSY_IN,
    output var  logic               CORE_HOLD_OUT,
    output var  logic               SUBSYSTEM_SELECT_OUT,
    output var  logic               PROGRAM_ADDR_BIT_18_OUT,
    output var  logic               PROGRAM_ADDR_BIT_18_OE_N_OUT,
    output var  logic [ADDR_W-1:0]  ADDR_OUT,
    output var  logic               ADDR_OE_N_OUT,
    output var  logic [DATA_W-1:0]  DATA_OUT,
    output var  logic               DATA_OE_N_OUT,
    output var  logic [CTRL_W-1:0]  CTRL_N_OUT,
    output var  logic               CTRL_OE_N_OUT,
    output var  logic               BUS_RELEASE_GRANT_N_OUT,
    output var  logic               BUS_RELEASE_GRANT_OE_N_OUT,
    output var  logic               MACHINE_CYCLE_CLOCK_OUT,
    output var  logic               MACHINE_CYCLE_CLOCK_OE_N_OUT
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    // Bus release state.
    ebrpc_state_type     state_q;
    ebrpc_state_type     state_d;

    // Software and pin state.
    logic [31:0]         pmode_q;
    logic [GRANT_W-1:0]  grants_q;
    logic                pready_q;
    logic                core_hold_q;
    logic                sel_q;

    // Divider outputs.
    logic                cycle_start;
    logic                clk_level;
    logic                clk_stopped;

    // ------------------------------------------------------------------
    // Pin level decode.
    // ------------------------------------------------------------------

    // The request pin is active low; inputs are already in this clock domain.
    // No synchroniser: the master must meet setup.
    wire req        = ~BUS_RELEASE_REQ_N_IN;
    wire float_n    = EMULATION_FLOAT_PIN_N_IN;
    wire xio_mode   = EXTERNAL_IO_MODE_PIN_IN;
    wire clk_off    = pmode_q[PMODE_CLKDIS];

    // One-hot state decode.
    wire is_wait    = (state_q == ST_WAIT);
    wire is_held    = (state_q == ST_HELD);

    // The bus is ours to drive only while not held and not floated.
    // Every bus pad lets go on the grant edge.
    wire bus_own    = ~is_held & float_n;
    wire data_drive = bus_own & CORE_BUS_IN.data_drive;
    wire a18_drive  = bus_own & xio_mode;
    wire grant_n    = ~is_held;

    // ------------------------------------------------------------------
    // Bus release state machine.
    // ------------------------------------------------------------------

    // Steps only on machine cycle boundaries, so a grant never lands mid-cycle.
    // A mid-cycle request waits for the boundary.
    // That costs up to one machine cycle.
    always_comb
    begin
        state_d = state_q;
        if (cycle_start)
        begin
            unique case (state_q)
                // A request first stalls the core.
                ST_RUN:
                begin
                    if (req)
                        state_d = ST_WAIT;
                end

                // Hand over only once the core is idle.
                ST_WAIT:
                begin
                    if (!req)
                        state_d = ST_RUN;
                    else if (!CORE_ACCESS_BUSY_IN)
                        state_d = ST_HELD;
                end

                // Hold until the request is withdrawn.
                ST_HELD:
                begin
                    if (!req)
                        state_d = ST_RUN;
                end
            endcase
        end
    end

    // State, core stall and grant counter.
    // The stall covers the wait, so no access starts.
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_q     <= ST_RUN;
            core_hold_q <= 1'b0;
            grants_q    <= GRANT_ZERO;
        end
        else
        begin
            state_q     <= state_d;
            core_hold_q <= (state_d != ST_RUN);
            if (state_d == ST_HELD && !is_held)
                grants_q <= grants_q + GRANT_ONE;
        end
    end

    assign CORE_HOLD_OUT = core_hold_q;

    // ------------------------------------------------------------------
    // Shared select pin.
    // ------------------------------------------------------------------

    // In external memory mode the pin is an output, so its input is masked.
    // One cycle late, but every reader sees one level.
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
            sel_q <= 1'b0;
        else
            sel_q <= ~xio_mode & SUBSYSTEM_SELECT_IN;
    end

    assign SUBSYSTEM_SELECT_OUT = sel_q;

    // ------------------------------------------------------------------
    // Output pads.
    // ------------------------------------------------------------------

    // Address bit 18 shares the select pin and follows the mode pin.
    // It floats with the address bus when held.
    ebrpc_pad_reg #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_pad_a18 (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (CORE_BUS_IN.addr_bit_18),
        .drive_in  (a18_drive),
        .value_out (PROGRAM_ADDR_BIT_18_OUT),
        .oe_n_out  (PROGRAM_ADDR_BIT_18_OE_N_OUT)
    );

    // Address lines float when lent out or floated.
    ebrpc_pad_reg #(
        .WIDTH     (ADDR_W),
        .RESET_VAL ('0)
    ) u_pad_addr (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (CORE_BUS_IN.addr),
        .drive_in  (bus_own),
        .value_out (ADDR_OUT),
        .oe_n_out  (ADDR_OE_N_OUT)
    );

    // Data lines drive only on core writes.
    ebrpc_pad_reg #(
        .WIDTH     (DATA_W),
        .RESET_VAL ('0)
    ) u_pad_data (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (CORE_BUS_IN.wdata),
        .drive_in  (data_drive),
        .value_out (DATA_OUT),
        .oe_n_out  (DATA_OE_N_OUT)
    );

    // Strobes idle high so a released bus sees no spurious access.
    // They float under the float pin as well.
    ebrpc_pad_reg #(
        .WIDTH     (CTRL_W),
        .RESET_VAL (CTRL_IDLE)
    ) u_pad_ctrl (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (CORE_BUS_IN.ctrl_n),
        .drive_in  (bus_own),
        .value_out (CTRL_N_OUT),
        .oe_n_out  (CTRL_OE_N_OUT)
    );

    // The grant floats with the float pin alone.
    // Its value keeps tracking the state.
    ebrpc_pad_reg #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) u_pad_grant (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (grant_n),
        .drive_in  (float_n),
        .value_out (BUS_RELEASE_GRANT_N_OUT),
        .oe_n_out  (BUS_RELEASE_GRANT_OE_N_OUT)
    );

    // ------------------------------------------------------------------
    // Machine cycle clock output.
    // ------------------------------------------------------------------
    // The disable bit acts on a boundary only,
    // so no clock phase is ever cut short.
    ebrpc_cycle_div u_div (
        .clk_in          (CLOCK_IN),
        .rst_n_in        (RST_N_IN),
        .stop_in         (clk_off),
        .cycle_start_out (cycle_start),
        .level_out       (clk_level),
        .stopped_out     (clk_stopped)
    );

    // The divider level is delayed one edge here, like every other pad.
    // So the clock lines up with the bus pads.
    ebrpc_pad_reg #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) u_pad_clk (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RST_N_IN),
        .value_in  (clk_level),
        .drive_in  (float_n),
        .value_out (MACHINE_CYCLE_CLOCK_OUT),
        .oe_n_out  (MACHINE_CYCLE_CLOCK_OE_N_OUT)
    );

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------

    // One wait state: ready is registered so every bus output is a flop.
    wire apb_access = PSEL_IN & PENABLE_IN;
    wire apb_done   = apb_access & pready_q;
    wire pready_d   = apb_access & ~pready_q;

    // Full compare; no aliased words.
    wire hit_pmode  = (PADDR_IN == ADDR_PMODE);
    wire hit_status = (PADDR_IN == ADDR_STATUS);
    wire hit_grants = (PADDR_IN == ADDR_GRANTS);
    wire hit_any    = hit_pmode | hit_status | hit_grants;
    wire wr_pmode   = apb_done & PWRITE_IN & hit_pmode;

    // Live state as seen by software.
    // No snapshot: two reads may differ.
    wire [ST_W-1:0] status_bits = {
        sel_q,
        clk_stopped,
        float_n,
        req,
        xio_mode,
        is_wait,
        core_hold_q,
        is_held
    };

    // Read mux; unmapped addresses read zero.
    // Zero outside the answer cycle, so no stale word.
    wire [31:0] rd_mux =
        hit_pmode  ? pmode_q :
        hit_status ? {{(32-ST_W){1'b0}}, status_bits} :
        hit_grants ? {{(32-GRANT_W){1'b0}}, grants_q} :
                     RDATA_IDLE;

    wire [31:0] rdata_d  = (pready_d & ~PWRITE_IN) ? rd_mux : RDATA_IDLE;
    wire        slverr_d = pready_d & ~hit_any;

    // ------------------------------------------------------------------
    // APB registers.
    // ------------------------------------------------------------------

    // Bus answer flops.
    // They hold for one answer cycle only.
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            pready_q    <= 1'b0;
            PRDATA_OUT  <= RDATA_IDLE;
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            pready_q    <= pready_d;
            PRDATA_OUT  <= rdata_d;
            PSLVERR_OUT <= slverr_d;
        end
    end

    assign PREADY_OUT = pready_q;

    // Only the clock disable bit is kept; other mode bits read as zero.
    // Status and count writes are dropped silently.
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
            pmode_q <= PMODE_RESET;
        else if (wr_pmode)
            pmode_q <= PWDATA_IN & PMODE_MASK;
    end

endmodule
`default_nettype wire

// ---- tb/ebrpc_ext_master.sv ----
`timescale 1ns/1ns
`default_nettype none

// Outside master that asks for the shared bus and gives it back after a set time.
module ebrpc_ext_master (
    input  wire logic       clk_in,
    input  wire logic       want_in,
    input  wire logic [7:0] hold_in,
    input  wire logic       grant_n_in,
    output var  logic       req_n_out,
    output var  logic       done_out
);
    logic [7:0] held_q;

    // A large hold_in makes a slow master; dropping want_in early withdraws the request.
    always_ff @(posedge clk_in)
    begin
        if (!want_in)
        begin
            req_n_out <= 1'b1;
            held_q    <= 8'h00;
            done_out  <= 1'b0;
        end
        else if (!done_out)
        begin
            req_n_out <= 1'b0;
            if (!grant_n_in)
                held_q <= held_q + 8'h01;
            if (held_q == hold_in)
            begin
                req_n_out <= 1'b1;
                done_out  <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- tb/ebrpc_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none

module ebrpc_top_sva
    import ebrpc_pkg::*;
(
    input  wire logic               CLOCK_IN,
    input  wire logic               RST_N_IN,
    input  wire logic               EXTERNAL_IO_MODE_PIN_IN,
    input  wire logic               EMULATION_FLOAT_PIN_N_IN,
    input  wire logic               BUS_RELEASE_REQ_N_IN,
    input  wire logic               SUBSYSTEM_SELECT_IN,
    input  wire ebrpc_core_bus_type CORE_BUS_IN,
    input  wire logic               CORE_ACCESS_BUSY_IN,
    input  wire logic               CORE_HOLD_OUT,
    input  wire logic               SUBSYSTEM_SELECT_OUT,
    input  wire logic               PROGRAM_ADDR_BIT_18_OUT,
    input  wire logic               PROGRAM_ADDR_BIT_18_OE_N_OUT,
    input  wire logic               ADDR_OE_N_OUT,
    input  wire logic               DATA_OE_N_OUT,
    input  wire logic               CTRL_OE_N_OUT,
    input  wire logic               BUS_RELEASE_GRANT_N_OUT,
    input  wire logic               BUS_RELEASE_GRANT_OE_N_OUT,
    input  wire logic               MACHINE_CYCLE_CLOCK_OUT,
    input  wire logic               MACHINE_CYCLE_CLOCK_OE_N_OUT
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ------
    // Pad float and shared pin direction.
    // ------
    AST_A18_FLOAT: assert property (!EMULATION_FLOAT_PIN_N_IN |=>
        PROGRAM_ADDR_BIT_18_OE_N_OUT && ADDR_OE_N_OUT) else $error("addr pads driven");
    AST_GRANT_FLOAT: assert property (!EMULATION_FLOAT_PIN_N_IN |=>
        BUS_RELEASE_GRANT_OE_N_OUT) else $error("grant pad driven");
    AST_CLK_FLOAT: assert property (!EMULATION_FLOAT_PIN_N_IN |=>
        MACHINE_CYCLE_CLOCK_OE_N_OUT) else $error("clock pad driven");
    AST_SEL_INPUT: assert property (!EXTERNAL_IO_MODE_PIN_IN |=>
        PROGRAM_ADDR_BIT_18_OE_N_OUT && SUBSYSTEM_SELECT_OUT == $past(SUBSYSTEM_SELECT_IN))
        else $error("select pin not an input");
    // The extra reset term keeps the check away from the pads' float after reset.
    AST_A18_DRIVE: assert property ($past(RST_N_IN) && EXTERNAL_IO_MODE_PIN_IN &&
        EMULATION_FLOAT_PIN_N_IN && !CORE_HOLD_OUT |=> !PROGRAM_ADDR_BIT_18_OE_N_OUT &&
        PROGRAM_ADDR_BIT_18_OUT == $past(CORE_BUS_IN.addr_bit_18)) else $error("bit 18 bad");

    // ------
    // Bus release and clock output.
    // ------
    AST_GRANT_BUS_FLOAT: assert property (!BUS_RELEASE_GRANT_N_OUT |->
        ADDR_OE_N_OUT && DATA_OE_N_OUT && CTRL_OE_N_OUT) else $error("bus driven in hold");
    AST_GRANT_AFTER_IDLE: assert property ($fell(BUS_RELEASE_GRANT_N_OUT) |->
        $past(CORE_HOLD_OUT) && !$past(CORE_ACCESS_BUSY_IN, 2)) else $error("grant too early");
    AST_GRANT_HOLDS: assert property (!BUS_RELEASE_GRANT_N_OUT && !BUS_RELEASE_REQ_N_IN &&
        !$past(BUS_RELEASE_REQ_N_IN) |=> !BUS_RELEASE_GRANT_N_OUT) else $error("grant lost");
    AST_CLK_SHAPE: assert property ($fell(MACHINE_CYCLE_CLOCK_OUT) |=>
        !MACHINE_CYCLE_CLOCK_OUT ##1 MACHINE_CYCLE_CLOCK_OUT [*2]) else $error("clock shape");

    COV_GRANT: cover property ($fell(BUS_RELEASE_GRANT_N_OUT));
    COV_CLK: cover property ($fell(MACHINE_CYCLE_CLOCK_OUT));
    COV_FLOAT: cover property (!EMULATION_FLOAT_PIN_N_IN);
    COV_REFUSE: cover property ($fell(CORE_HOLD_OUT) && BUS_RELEASE_GRANT_N_OUT);
endmodule

bind ebrpc_top ebrpc_top_sva u_sva (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .EXTERNAL_IO_MODE_PIN_IN(EXTERNAL_IO_MODE_PIN_IN),
    .EMULATION_FLOAT_PIN_N_IN(EMULATION_FLOAT_PIN_N_IN),
    .BUS_RELEASE_REQ_N_IN(BUS_RELEASE_REQ_N_IN), .SUBSYSTEM_SELECT_IN(SUBSYSTEM_SELECT_IN),
    .CORE_BUS_IN(CORE_BUS_IN), .CORE_ACCESS_BUSY_IN(CORE_ACCESS_BUSY_IN),
    .CORE_HOLD_OUT(CORE_HOLD_OUT), .SUBSYSTEM_SELECT_OUT(SUBSYSTEM_SELECT_OUT),
    .PROGRAM_ADDR_BIT_18_OUT(PROGRAM_ADDR_BIT_18_OUT),
    .PROGRAM_ADDR_BIT_18_OE_N_OUT(PROGRAM_ADDR_BIT_18_OE_N_OUT),
    .ADDR_OE_N_OUT(ADDR_OE_N_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT),
    .CTRL_OE_N_OUT(CTRL_OE_N_OUT), .BUS_RELEASE_GRANT_N_OUT(BUS_RELEASE_GRANT_N_OUT),
    .BUS_RELEASE_GRANT_OE_N_OUT(BUS_RELEASE_GRANT_OE_N_OUT),
    .MACHINE_CYCLE_CLOCK_OUT(MACHINE_CYCLE_CLOCK_OUT),
    .MACHINE_CYCLE_CLOCK_OE_N_OUT(MACHINE_CYCLE_CLOCK_OE_N_OUT));

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import ebrpc_pkg::*;

    logic clk, rst_n, psel, pen, pwr, mode, flt_n, sel, busy, want, prdy, perr, er;
    logic req_n, done, chold, sel_o, a18, a18_oe, aoe, doe, coe, gnt_n, goe, mclk, moe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [17:0] addr;
    logic [15:0] data;
    logic [3:0]  ctrl;
    logic [7:0]  hold;
    ebrpc_core_bus_type cbus;
    int mismatches, cmp_count, cyc;

    ebrpc_top DUT (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .EXTERNAL_IO_MODE_PIN_IN(mode),
        .EMULATION_FLOAT_PIN_N_IN(flt_n), .BUS_RELEASE_REQ_N_IN(req_n),
        .SUBSYSTEM_SELECT_IN(sel), .CORE_BUS_IN(cbus), .CORE_ACCESS_BUSY_IN(busy),
        .CORE_HOLD_OUT(chold), .SUBSYSTEM_SELECT_OUT(sel_o),
        .PROGRAM_ADDR_BIT_18_OUT(a18), .PROGRAM_ADDR_BIT_18_OE_N_OUT(a18_oe),
        .ADDR_OUT(addr), .ADDR_OE_N_OUT(aoe), .DATA_OUT(data), .DATA_OE_N_OUT(doe),
        .CTRL_N_OUT(ctrl), .CTRL_OE_N_OUT(coe), .BUS_RELEASE_GRANT_N_OUT(gnt_n),
        .BUS_RELEASE_GRANT_OE_N_OUT(goe), .MACHINE_CYCLE_CLOCK_OUT(mclk),
        .MACHINE_CYCLE_CLOCK_OE_N_OUT(moe));

    ebrpc_ext_master u_master (.clk_in(clk), .want_in(want), .hold_in(hold),
        .grant_n_in(gnt_n), .req_n_out(req_n), .done_out(done));

    // Free-running reference clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // A hung wait must still end in the verdict.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    // ------
    // Shared tasks.
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer; it idles one edge first so no request is re-driven at once.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (prdy !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic count_falls(output int f);
        logic last;
        f = 0;
        last = mclk;
        repeat (40)
        begin
            @(posedge clk);
            if (last === 1'b1 && mclk === 1'b0)
                f++;
            last = mclk;
        end
    endtask

    // ------
    // Scenarios.
    // ------
    task automatic t_reg;
        apb(1'b0, ADDR_PMODE, 32'h0);
        chk(rd, PMODE_RESET);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF);
        chk(er, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_GRANTS, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_sel;
        sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk({sel_o, a18_oe}, 2'h3);
        mode <= 1'b1;
        cbus.addr_bit_18 <= 1'b1;
        repeat (3) @(posedge clk);
        chk({a18_oe, a18, sel_o}, 3'h2);
        cbus.addr_bit_18 <= 1'b0;
        repeat (3) @(posedge clk);
        chk({a18_oe, a18}, 2'h0);
    endtask

    task automatic t_flt;
        flt_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({a18_oe, aoe}, 2'h3);
        chk(goe, 1'b1);
        chk(moe, 1'b1);
        flt_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({goe, moe}, 2'h0);
    endtask

    task automatic t_clk;
        int n;
        count_falls(n);
        chk(n, 10);
        apb(1'b1, ADDR_PMODE, 32'hFFFFFFFF);
        apb(1'b0, ADDR_PMODE, 32'h0);
        chk(rd, PMODE_MASK);
        repeat (8) @(posedge clk);
        count_falls(n);
        chk({n[7:0], mclk}, 9'h001);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[ST_CYCLE_CLOCK_OUT_DISABLE], 1'b1);
        apb(1'b1, ADDR_PMODE, 32'h0);
        repeat (8) @(posedge clk);
        count_falls(n);
        chk(n, 10);
    endtask

    // The core is busy first, so the grant has to wait for it.
    task automatic t_hold;
        int n;
        busy <= 1'b1;
        want <= 1'b1;
        for (n = 0; n < 40 && chold !== 1'b1; n++) @(posedge clk);
        repeat (12) @(posedge clk);
        chk({chold, gnt_n}, 2'h3);
        busy <= 1'b0;
        for (n = 0; n < 40 && gnt_n !== 1'b0; n++) @(posedge clk);
        chk({gnt_n, goe}, 2'h0);
        chk({aoe, doe, coe}, 3'h7);
        for (n = 0; n < 80 && gnt_n !== 1'b1; n++) @(posedge clk);
        chk(n > 15, 1'b1);
        chk({gnt_n, aoe, addr}, {2'h2, 18'h25A5A});
        chk({data, ctrl, doe, coe}, {16'hC3A5, 6'h00});
        want <= 1'b0;
        apb(1'b0, ADDR_GRANTS, 32'h0);
        chk(rd, 32'h1);
    endtask

    // Request withdrawn while waiting: no grant may follow.
    task automatic t_refuse;
        int n;
        busy <= 1'b1;
        want <= 1'b1;
        for (n = 0; n < 40 && chold !== 1'b1; n++) @(posedge clk);
        want <= 1'b0;
        for (n = 0; n < 40 && chold !== 1'b0; n++) @(posedge clk);
        chk({chold, gnt_n}, 2'h1);
        busy <= 1'b0;
        apb(1'b0, ADDR_GRANTS, 32'h0);
        chk(rd, 32'h1);
    endtask

    // Main sequence.
    initial
    begin
        {rst_n, psel, pen, pwr, mode, sel, busy, want, paddr, pwdata} = '0;
        {mismatches, cmp_count, cyc} = '0;
        flt_n = 1'b1;
        hold = 8'd20;
        cbus = '0;
        cbus.addr = 18'h25A5A;
        cbus.data_drive = 1'b1;
        cbus.wdata = 16'hC3A5;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reg();
        t_sel();
        t_flt();
        t_clk();
        t_hold();
        t_refuse();
        report_and_stop();
    end
endmodule

`default_nettype wire
